/* hw/sysctl_pkg.sv */
// Purpose: Shared constants for the system-control register subset.
// Assumes: Registers are reached by coprocessor move register number and select.
// Notes:   Field positions are bit indices within the 32-bit register word.
package sysctl_pkg;
   localparam logic [4:0] REG_ENTRY_HIGH = 5'h0A;
   localparam logic [4:0] REG_COMPARE    = 5'h0B;
   localparam logic [4:0] REG_STATUS     = 5'h0C;
   localparam logic [2:0] SEL_MAIN       = 3'h0;

   localparam int VPN_HI   = 31;
   localparam int VPN_LO   = 13;
   localparam int TAG_HI   = 7;
   localparam int TAG_LO   = 0;

   localparam int CU_LO    = 28;
   localparam int RP_POS   = 27;
   localparam int FR_POS   = 26;
   localparam int MX_POS   = 24;
   localparam int BEV_POS  = 22;
   localparam int NMI_POS  = 19;
   localparam int IM_HI    = 15;
   localparam int IM_LO    = 8;
   localparam int KSU_HI   = 4;
   localparam int KSU_LO   = 3;
   localparam int ERL_POS  = 2;
   localparam int EXL_POS  = 1;
   localparam int IE_POS   = 0;

   localparam logic [1:0] KSU_KERNEL = 2'h0;
   localparam logic [1:0] KSU_SUPER  = 2'h1;
   localparam logic [1:0] KSU_USER   = 2'h2;

   localparam logic       ERL_RESET  = 1'h1;
   localparam logic       BEV_RESET  = 1'h1;
   localparam logic       RP_RESET   = 1'h0;
   localparam logic       FR_RESET   = 1'h0;
   localparam logic       MX_RESET   = 1'h0;
   localparam logic       NMI_RESET  = 1'h0;
   localparam logic       CU3_RESET  = 1'h0;
   localparam logic [31:0] CMP_RESET = 32'h0000_0000;
endpackage

/* hw/cmp_if.sv */
// Purpose: Carrier between the register bank and its compare timer unit.
// Assumes: One clock domain.
// Notes:   The bank owns decode; the timer owns the compare value and the flag.
`timescale 1ns/100ps
`default_nettype none
interface cmp_if;
   logic        wrStb;
   logic [31:0] wrData;
   logic [31:0] countVal;
   logic [31:0] value;
   logic        irq;
   modport bank  (output wrStb, output wrData, output countVal, input value, input irq);
   modport timer (input wrStb, input wrData, input countVal, output value, output irq);
endinterface
`default_nettype wire

/* hw/timer_compare_unit.sv */
// Purpose: Compare register and the timer interrupt flag.
// Assumes: The count value is supplied from outside, synchronous to clk.
// Notes:   The flag is sticky until the next compare write.
`timescale 1ns/100ps
`default_nettype none
module timer_compare_unit
   import sysctl_pkg::*;
(
   input  wire logic clk,
   input  wire logic rstn,
   cmp_if.timer      cmp
);
   logic [31:0] value_r;
   logic        irq_r;

   // The value only moves on a software write.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         value_r <= CMP_RESET;
      end else if (cmp.wrStb) begin
         value_r <= cmp.wrData; // R7
      end
   end

   // A match in the same cycle as a write wins, so no match is lost.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         irq_r <= 1'b0;
      end else if (cmp.countVal == value_r) begin
         irq_r <= 1'b1; // R6
      end else if (cmp.wrStb) begin
         irq_r <= 1'b0; // R6
      end
   end

   assign cmp.value = value_r;
   assign cmp.irq   = irq_r;
endmodule
`default_nettype wire

/* hw/sys_ctrl_status_timer_vpn_regs.sv */
// Purpose: Translation entry-high, compare and status registers with mode decode.
// Assumes: Move requests and exception events are single-cycle pulses on clk.
// Notes:   Read data lags its address by one clock; mode outputs lag a status write or exception by two.
`timescale 1ns/100ps
`default_nettype none
// Operation
// R1: TLB refill, invalid or modified exception loads address bits 31..13 into page pair.
// R2: TLB read instruction overwrites page pair and tag from the chosen entry.
// R3: Written tag is compared with each entry's tag to decide a match.
// R4: Entry-high bits 12..8 read zero; software writes zeros there.
// R5: Software write of entry-high touches no faulting-address or context register.
// R6: Count equal to compare raises the timer output until compare is written.
// R7: Compare holds its last written value and is readable and writable.
// R8: Interrupts enabled only with master enable set and exception, error, debug clear.
// R9: Debug flag set means debug mode, with all kernel-mode access.
// R10: Without debug, kernel mode when base mode 00 or exception or error level set.
// R11: Supervisor when base mode 01, levels clear; absent with fixed mapping.
// R12: User mode when base mode 10, no debug, both levels clear.
// R13: Kernel mode at power-up and on any exception; left when conditions clear.
// R14: Access to a coprocessor with its usable bit clear raises an exception.
// R15: Kernel mode may always access coprocessor 0.
// R16: Usable bit 29 writable only with a floating point unit, else reads zero.
// R17: Usable bit 30 needs coprocessor 2, else zero; bit 31 reserved, resets zero.
// R18: Low-power bit 27 resets zero and drives the reduced-power output.
// R19: Bit 26 selects paired or full-width float registers; zero without 64-bit unit.
// R20: DSP enable bit 24 clear makes DSP instructions fault; read-only without DSP.
// R21: Boot vector bit 22 resets to one and selects bootstrap vectors.
// R22: Bits 21 and 20 always read zero; conflicting translation writes dropped quietly.
// R23: Non-maskable flag is cleared by writing zero and cannot be set by software.
// R24: Exception level set on any exception other than reset or non-maskable.
// R25: Non-maskable flag set on non-maskable entry, cleared by ordinary reset.
module sys_ctrl_status_timer_vpn_regs
   import sysctl_pkg::*;
#(
   parameter bit HAS_FPU   = 1'b1,
   parameter bit HAS_FPU64 = 1'b1,
   parameter bit HAS_COP2  = 1'b0,
   parameter bit HAS_DSP   = 1'b1,
   parameter bit FIXED_MAP = 1'b0
)
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        mvWrEn,
   input  wire logic [4:0]  mvRegNum,
   input  wire logic [2:0]  mvSel,
   input  wire logic [31:0] mvWrData,
   output var  logic [31:0] mvRdData,
   input  wire logic        tlbExcTaken,
   input  wire logic [31:0] excVaddr,
   input  wire logic        tlbReadDo,
   input  wire logic [18:0] tlbRdPage,
   input  wire logic [7:0]  tlbRdTag,
   input  wire logic [7:0]  entryTag,
   output var  logic        tagMatch,
   input  wire logic        excTaken,
   input  wire logic        nmiTaken,
   input  wire logic        eretDo,
   input  wire logic        debugFlag,
   input  wire logic [31:0] countValue,
   output var  logic        timerIrqOut,
   output var  logic        lowPowerOut,
   input  wire logic        cpAccess,
   input  wire logic [1:0]  cpAccessNum,
   output var  logic        cpUnusable,
   input  wire logic        dspInstr,
   output var  logic        dspDisabled,
   output var  logic        kernelMode,
   output var  logic        supervisorMode,
   output var  logic        userMode,
   output var  logic        debugMode,
   output var  logic        irqGlobalEn,
   output var  logic [7:0]  irqMask,
   output var  logic        fprFullWidth,
   output var  logic        bootVectors
);
   function automatic logic regHit(input logic [4:0] num,
                                   input logic [2:0] sel,
                                   input logic [4:0] target);
      regHit = (num == target) && (sel == SEL_MAIN);
   endfunction

   logic [18:0] page_r;
   logic [7:0]  tag_r;
   logic [3:0]  cu_r;
   logic        rp_r;
   logic        fr_r;
   logic        mx_r;
   logic        bev_r;
   logic        nmi_r;
   logic [7:0]  im_r;
   logic [1:0]  ksu_r;
   logic        erl_r;
   logic        exl_r;
   logic        ie_r;
   logic        kernelNow;
   logic        wrEntry;
   logic        wrStatus;
   logic [31:0] statusWord;
   logic [31:0] entryWord;
   logic [3:0]  cuEff;
   logic        tagMatch_r;
   logic        cpUnusable_r;
   logic        dspDisabled_r;
   logic        kernel_r;
   logic        super_r;
   logic        user_r;
   logic        debug_r;
   logic        irqEn_r;
   logic [31:0] rdData_r;

   cmp_if cmp ();

   timer_compare_unit u_timer (
      .clk  (clk),
      .rstn (rstn),
      .cmp  (cmp.timer)
   );

   assign wrEntry      = mvWrEn && regHit(mvRegNum, mvSel, REG_ENTRY_HIGH);
   assign wrStatus     = mvWrEn && regHit(mvRegNum, mvSel, REG_STATUS);
   assign cmp.wrStb    = mvWrEn && regHit(mvRegNum, mvSel, REG_COMPARE);
   assign cmp.wrData   = mvWrData;
   assign cmp.countVal = countValue;

   // Hardware loads take priority over a software write in the same cycle.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         page_r <= '0;
      end else if (tlbExcTaken) begin
         page_r <= excVaddr[VPN_HI:VPN_LO]; // R1
      end else if (tlbReadDo) begin
         page_r <= tlbRdPage; // R2
      end else if (wrEntry) begin
         page_r <= mvWrData[VPN_HI:VPN_LO];
      end
   end

   // Software must save the tag around a translation read; it is clobbered.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         tag_r <= '0;
      end else if (tlbReadDo) begin
         tag_r <= tlbRdTag; // R2
      end else if (wrEntry) begin
         tag_r <= mvWrData[TAG_HI:TAG_LO]; // R5
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         tagMatch_r <= 1'b0;
      end else begin
         tagMatch_r <= (entryTag == tag_r); // R3
      end
   end

   // Absent units keep their usable bits at zero whatever is written.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cu_r <= {CU3_RESET, 3'h0}; // R17
      end else if (wrStatus) begin
         cu_r[0] <= mvWrData[CU_LO];
         cu_r[1] <= HAS_FPU && mvWrData[CU_LO + 1]; // R16
         cu_r[2] <= HAS_COP2 && mvWrData[CU_LO + 2]; // R17
         cu_r[3] <= CU3_RESET; // R17
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rp_r <= RP_RESET; // R18
      end else if (wrStatus) begin
         rp_r <= mvWrData[RP_POS]; // R18
      end
   end

   // Paired-register mode is forced whenever no 64-bit unit could use full width.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         fr_r <= FR_RESET;
      end else if (wrStatus) begin
         fr_r <= HAS_FPU && HAS_FPU64 && mvWrData[FR_POS]; // R19
      end
   end

   // Without DSP hardware the enable is read-only and stays at its reset value.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         mx_r <= MX_RESET;
      end else if (wrStatus) begin
         mx_r <= HAS_DSP ? mvWrData[MX_POS] : MX_RESET; // R20
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         bev_r <= BEV_RESET; // R21
      end else if (wrStatus) begin
         bev_r <= mvWrData[BEV_POS]; // R21
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         im_r <= '0;
      end else if (wrStatus) begin
         im_r <= mvWrData[IM_HI:IM_LO];
      end
   end

   // The reserved base mode code is stored as written; it decodes to no mode.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ksu_r <= KSU_KERNEL;
      end else if (wrStatus) begin
         ksu_r <= mvWrData[KSU_HI:KSU_LO];
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         ie_r <= 1'b0;
      end else if (wrStatus) begin
         ie_r <= mvWrData[IE_POS]; // R8
      end
   end

   // Taking an exception beats a software write or a return in the same cycle.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         exl_r <= 1'b0;
      end else if (excTaken) begin
         exl_r <= 1'b1; // R24
      end else if (eretDo && !erl_r) begin
         exl_r <= 1'b0; // R13
      end else if (wrStatus) begin
         exl_r <= mvWrData[EXL_POS];
      end
   end

   // Error level comes up set, so the core starts in kernel mode.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         erl_r <= ERL_RESET; // R13
      end else if (nmiTaken) begin
         erl_r <= 1'b1; // R13
      end else if (eretDo && erl_r) begin
         erl_r <= 1'b0; // R13
      end else if (wrStatus) begin
         erl_r <= mvWrData[ERL_POS];
      end
   end

   // Entry by non-maskable interrupt wins over a clearing write.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         nmi_r <= NMI_RESET; // R25
      end else if (nmiTaken) begin
         nmi_r <= 1'b1; // R25
      end else if (wrStatus && !mvWrData[NMI_POS]) begin
         nmi_r <= 1'b0; // R23
      end
   end

   assign kernelNow = debugFlag || (ksu_r == KSU_KERNEL) || exl_r || erl_r; // R9 R10

   // Kernel and debug mode may always reach coprocessor 0.
   assign cuEff = {cu_r[3:1], cu_r[0] | kernelNow}; // R15

   always_ff @(posedge clk) begin
      if (!rstn) begin
         cpUnusable_r <= 1'b0;
      end else begin
         cpUnusable_r <= cpAccess && !cuEff[cpAccessNum]; // R14
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         dspDisabled_r <= 1'b0;
      end else begin
         dspDisabled_r <= dspInstr && !mx_r; // R20
      end
   end

   // Reserved base mode 11 decodes to none of the three base modes.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         kernel_r <= 1'b1;
         super_r  <= 1'b0;
         user_r   <= 1'b0;
         debug_r  <= 1'b0;
      end else begin
         debug_r  <= debugFlag; // R9
         kernel_r <= kernelNow; // R10 R13
         super_r  <= !debugFlag && !FIXED_MAP && (ksu_r == KSU_SUPER)
                     && !exl_r && !erl_r; // R11
         user_r   <= !debugFlag && (ksu_r == KSU_USER) && !exl_r && !erl_r; // R12
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         irqEn_r <= 1'b0;
      end else begin
         irqEn_r <= ie_r && !exl_r && !erl_r && !debugFlag; // R8
      end
   end

   // Translation shutdown and soft reset stay zero; bits 25, 23, 18..16, 7..5 too.
   assign statusWord = {cu_r, rp_r, fr_r, 1'b0, mx_r, 1'b0, bev_r,
                        1'b0, 1'b0, nmi_r, 3'h0, im_r, 3'h0,
                        ksu_r, erl_r, exl_r, ie_r}; // R22
   assign entryWord  = {page_r, 5'h00, tag_r}; // R4

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rdData_r <= '0;
      end else if (regHit(mvRegNum, mvSel, REG_ENTRY_HIGH)) begin
         rdData_r <= entryWord;
      end else if (regHit(mvRegNum, mvSel, REG_COMPARE)) begin
         rdData_r <= cmp.value; // R7
      end else if (regHit(mvRegNum, mvSel, REG_STATUS)) begin
         rdData_r <= statusWord;
      end else begin
         rdData_r <= '0;
      end
   end

   assign mvRdData       = rdData_r;
   assign tagMatch       = tagMatch_r;
   assign timerIrqOut    = cmp.irq; // R6
   assign lowPowerOut    = rp_r; // R18
   assign cpUnusable     = cpUnusable_r;
   assign dspDisabled    = dspDisabled_r;
   assign kernelMode     = kernel_r;
   assign supervisorMode = super_r;
   assign userMode       = user_r;
   assign debugMode      = debug_r;
   assign irqGlobalEn    = irqEn_r;
   assign irqMask        = im_r;
   assign fprFullWidth   = fr_r; // R19
   assign bootVectors    = bev_r; // R21
endmodule
`default_nettype wire

/* sim/sysctl_props.sv */
// Purpose: Concurrent checks on the register bank ports.
// Assumes: One clock, synchronous active-low reset.
// Notes:   A compare shadow predicts the timer output.
`timescale 1ns/100ps
`default_nettype none
module sysctl_props
   import sysctl_pkg::*;
(
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        mvWrEn,
   input wire logic [4:0]  mvRegNum,
   input wire logic [2:0]  mvSel,
   input wire logic [31:0] mvWrData,
   input wire logic [31:0] mvRdData,
   input wire logic [31:0] countValue,
   input wire logic        timerIrqOut,
   input wire logic        lowPowerOut,
   input wire logic        excTaken,
   input wire logic        debugFlag,
   input wire logic        debugMode,
   input wire logic        userMode,
   input wire logic        kernelMode,
   input wire logic        irqGlobalEn,
   input wire logic        cpAccess,
   input wire logic [1:0]  cpAccessNum,
   input wire logic        cpUnusable
);
   default clocking cbMain @(posedge clk); endclocking
   default disable iff (!rstn);
   logic [31:0] cmpShadow_r;
   logic        cmpWr;
   logic        stWr;
   assign cmpWr = mvWrEn && mvRegNum == REG_COMPARE && mvSel == SEL_MAIN;
   assign stWr  = mvWrEn && mvRegNum == REG_STATUS && mvSel == SEL_MAIN;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cmpShadow_r <= CMP_RESET;
      end else if (cmpWr) begin
         cmpShadow_r <= mvWrData;
      end
   end
   chk_irq_on_match: assert property (countValue == cmpShadow_r |=> timerIrqOut)
      else $error("timer output not raised on match");
   chk_irq_holds: assert property (timerIrqOut && !cmpWr |=> timerIrqOut)
      else $error("timer output dropped without compare write");
   chk_irq_clear_wr: assert property (cmpWr && countValue != cmpShadow_r |=> !timerIrqOut)
      else $error("timer output not cleared by compare write");
   chk_entry_hole_zero: assert property (mvRegNum == REG_ENTRY_HIGH && mvSel == SEL_MAIN
      |=> mvRdData[12:8] == 5'h00)
      else $error("entry-high hole bits not zero");
   chk_status_fixed_zero: assert property (mvRegNum == REG_STATUS && mvSel == SEL_MAIN
      |=> (mvRdData & 32'hC2B7_00E0) == 32'h0000_0000)
      else $error("status fixed-zero bits set");
   chk_low_power_follow: assert property (stWr |=> lowPowerOut == $past(mvWrData[RP_POS]))
      else $error("low power output does not follow status");
   chk_exc_kernel: assert property (excTaken |-> ##2 (kernelMode && !irqGlobalEn))
      else $error("exception did not force kernel mode");
   chk_debug_mode: assert property (debugFlag |=> debugMode && !irqGlobalEn && !userMode)
      else $error("debug flag not reflected");
   chk_cp_upper_unusable: assert property (cpAccess && cpAccessNum[1] |=> cpUnusable)
      else $error("absent coprocessor access not refused");
   chk_cp_no_cause: assert property (!cpAccess |=> !cpUnusable)
      else $error("coprocessor fault without access");
endmodule
bind sys_ctrl_status_timer_vpn_regs sysctl_props i_sysctl_props (.clk, .rstn, .mvWrEn,
   .mvRegNum, .mvSel, .mvWrData, .mvRdData, .countValue, .timerIrqOut, .lowPowerOut,
   .excTaken, .debugFlag, .debugMode, .userMode, .kernelMode, .irqGlobalEn, .cpAccess,
   .cpAccessNum, .cpUnusable);
`default_nettype wire

/* sim/sys_partner_model.sv */
// Purpose: System-side free-running count source for the compare timer.
// Assumes: Count advances once per clock; a load pulse presets it.
// Notes:   Presetting lets a match be reached in a few cycles.
`timescale 1ns/100ps
`default_nettype none
module sys_partner_model (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        load,
   input  wire logic [31:0] loadVal,
   output var  logic [31:0] countValue
);
   always_ff @(posedge clk) begin
      if (!rstn) begin
         countValue <= 32'h0000_0000;
      end else if (load) begin
         countValue <= loadVal;
      end else begin
         countValue <= countValue + 32'h0000_0001;
      end
   end
endmodule
`default_nettype wire

/* sim/sys_ctrl_status_timer_vpn_regs_bench.sv */
// Purpose: Self-checking bench for the register bank.
// Assumes: Inputs change on the falling edge.
// Notes:   Read data is taken one clock after the address.
`timescale 1ns/100ps
`default_nettype none
module sys_ctrl_status_timer_vpn_regs_bench
   import sysctl_pkg::*;
;
   logic clk = 1'b0;
   logic rstn, mvWrEn, tlbExcTaken, tlbReadDo, excTaken, nmiTaken, eretDo, debugFlag;
   logic cpAccess, dspInstr, load, tagMatch, timerIrqOut, lowPowerOut, cpUnusable;
   logic dspDisabled, kernelMode, supervisorMode, userMode, debugMode, irqGlobalEn;
   logic fprFullWidth, bootVectors;
   logic [4:0] mvRegNum;
   logic [2:0] mvSel;
   logic [1:0] cpAccessNum;
   logic [7:0] tlbRdTag, entryTag, irqMask;
   logic [18:0] tlbRdPage;
   logic [31:0] mvWrData, mvRdData, excVaddr, countValue, loadVal;
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;
   always #50 clk = ~clk;
   sys_ctrl_status_timer_vpn_regs i_sys_ctrl_status_timer_vpn_regs (.clk, .rstn, .mvWrEn,
      .mvRegNum, .mvSel, .mvWrData, .mvRdData, .tlbExcTaken, .excVaddr, .tlbReadDo,
      .tlbRdPage, .tlbRdTag, .entryTag, .tagMatch, .excTaken, .nmiTaken, .eretDo,
      .debugFlag, .countValue, .timerIrqOut, .lowPowerOut, .cpAccess, .cpAccessNum,
      .cpUnusable, .dspInstr, .dspDisabled, .kernelMode, .supervisorMode, .userMode,
      .debugMode, .irqGlobalEn, .irqMask, .fprFullWidth, .bootVectors);
   sys_partner_model i_sys_partner_model (.clk, .rstn, .load, .loadVal, .countValue);
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // A hung wait would otherwise never reach the verdict.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         finish_test();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr(input logic [4:0] num, input logic [31:0] d);
      mvWrEn = 1'b1;
      mvRegNum = num;
      mvWrData = d;
      cyc(1);
      mvWrEn = 1'b0;
   endtask
   task automatic rdChk(input logic [4:0] num, input logic [31:0] exp);
      mvRegNum = num;
      cyc(1);
      chk(mvRdData, exp);
   endtask
   task automatic t_reset();
      chk(kernelMode, 1'b1);
      chk(bootVectors, 1'b1);
      rdChk(REG_STATUS, 32'h0040_0004);
      chk(timerIrqOut, 1'b1);
      $display("test reset done");
   endtask
   task automatic t_entry();
      wr(REG_ENTRY_HIGH, 32'hFFFF_FFFF);
      rdChk(REG_ENTRY_HIGH, 32'hFFFF_E0FF);
      excVaddr = 32'h1234_5678;
      tlbExcTaken = 1'b1;
      wr(REG_ENTRY_HIGH, 32'h0000_0033);
      tlbExcTaken = 1'b0;
      rdChk(REG_ENTRY_HIGH, 32'h1234_4033);
      tlbRdPage = 19'h00001;
      tlbRdTag = 8'h5A;
      tlbReadDo = 1'b1;
      cyc(1);
      tlbReadDo = 1'b0;
      rdChk(REG_ENTRY_HIGH, 32'h0000_205A);
      entryTag = 8'h5A;
      cyc(1);
      chk(tagMatch, 1'b1);
      entryTag = 8'h5B;
      cyc(1);
      chk(tagMatch, 1'b0);
      $display("test entry-high done");
   endtask
   task automatic t_compare();
      int n;
      wr(REG_COMPARE, 32'h0000_0100);
      chk(timerIrqOut, 1'b0);
      rdChk(REG_COMPARE, 32'h0000_0100);
      mvSel = 3'h1;
      rdChk(REG_COMPARE, 32'h0000_0000);
      mvSel = SEL_MAIN;
      rdChk(5'h0D, 32'h0000_0000);
      loadVal = 32'h0000_00FC;
      load = 1'b1;
      cyc(1);
      load = 1'b0;
      n = 0;
      while (timerIrqOut !== 1'b1 && n < 20) begin
         cyc(1);
         n++;
      end
      chk(n, 5);
      cyc(3);
      chk(timerIrqOut, 1'b1);
      wr(REG_COMPARE, 32'hFFFF_0000);
      chk(timerIrqOut, 1'b0);
      $display("test compare done");
   endtask
   task automatic t_status();
      logic [31:0] val [5] = '{32'h0000_A511, 32'h0000_0009, 32'h0000_0013,
                               32'h0000_0015, 32'h0000_0001};
      logic [3:0]  exp [5] = '{4'h3, 4'h5, 4'h8, 4'h8, 4'h9};
      wr(REG_STATUS, 32'hFFFF_FFFF);
      rdChk(REG_STATUS, 32'h3D40_FF1F);
      chk(lowPowerOut, 1'b1);
      chk(fprFullWidth, 1'b1);
      for (int i = 0; i < 5; i++) begin
         wr(REG_STATUS, val[i]);
         cyc(1);
         chk({kernelMode, supervisorMode, userMode, irqGlobalEn}, exp[i]);
      end
      chk(irqMask, 8'h00);
      chk(lowPowerOut, 1'b0);
      chk(bootVectors, 1'b0);
      $display("test status modes done");
   endtask
   task automatic t_events();
      wr(REG_STATUS, 32'h0000_0011);
      dspInstr = 1'b1;
      cpAccess = 1'b1;
      cpAccessNum = 2'h0;
      cyc(1);
      dspInstr = 1'b0;
      cpAccess = 1'b0;
      chk({dspDisabled, cpUnusable, userMode}, 3'h7);
      excTaken = 1'b1;
      cyc(1);
      excTaken = 1'b0;
      cpAccess = 1'b1;
      cyc(1);
      cpAccess = 1'b0;
      chk({kernelMode, cpUnusable, dspDisabled}, 3'h4);
      cpAccessNum = 2'h2;
      cpAccess = 1'b1;
      cyc(1);
      cpAccess = 1'b0;
      chk(cpUnusable, 1'b1);
      eretDo = 1'b1;
      cyc(1);
      eretDo = 1'b0;
      cyc(1);
      chk(userMode, 1'b1);
      nmiTaken = 1'b1;
      cyc(1);
      nmiTaken = 1'b0;
      rdChk(REG_STATUS, 32'h0008_0015);
      wr(REG_STATUS, 32'h0000_0011);
      cyc(1);
      wr(REG_STATUS, 32'h0008_0011);
      rdChk(REG_STATUS, 32'h0000_0011);
      debugFlag = 1'b1;
      cyc(2);
      chk({debugMode, irqGlobalEn}, 2'h2);
      debugFlag = 1'b0;
      $display("test events done");
   endtask
   initial begin
      {rstn, mvWrEn, tlbExcTaken, tlbReadDo, excTaken, nmiTaken, eretDo} = '0;
      {debugFlag, cpAccess, dspInstr, load, cpAccessNum, tlbRdTag, entryTag} = '0;
      {tlbRdPage, mvRegNum, mvWrData, excVaddr, loadVal} = '0;
      mvSel = SEL_MAIN;
      cyc(3);
      rstn = 1'b1;
      t_reset();
      t_entry();
      t_compare();
      t_status();
      t_events();
      rstn = 1'b0;
      cyc(3);
      rstn = 1'b1;
      t_reset();
      finish_test();
   end
endmodule
`default_nettype wire
